// file: shared/pnvbm_pkg.sv
// Functional notes
// - Host gives one write strobe low pulse per byte written.
// - New random-row access allowed while selected, at most one per cycle time.
// - In select-ended write, host holds data valid at deselect.
// - Host meets access time before ending a write.
// - Page read: host changes only column bits; new byte driven without toggle.
// - Page write: each extra strobe with new column writes same row.
// - Host keeps deselected select inactive at least minimum precharge time.
// - With selects tied active, host keeps write strobe high at power cycles.
package pnvbm_pkg;
  localparam int ADDR_W = 17;
  localparam int DATA_W = 8;
  localparam int COL_W = 3;
  localparam int ROW_W = 14;
  localparam int CLK_PERIOD_PS = 5000;
  // Timing figures in ns
  localparam int ADDRESS_ACCESS_TIME_NS = 90;
  localparam int RANDOM_CYCLE_TIME_NS = 90;
  localparam int RANDOM_WRITE_CYCLE_TIME_NS = 90;
  localparam int MIN_PRECHARGE_TIME_NS = 30;
  localparam int PAGE_ACCESS_TIME_NS = 30;
  localparam int OUT_RELEASE_TIME_NS = 10;
  // Cycle counts: least times round up
  localparam int T_AA_CYC = (ADDRESS_ACCESS_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int T_RC_CYC = (RANDOM_CYCLE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int T_WC_CYC = (RANDOM_WRITE_CYCLE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int T_PC_CYC = (MIN_PRECHARGE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int T_AAP_CYC = (PAGE_ACCESS_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int T_HZ_CYC = (OUT_RELEASE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CNT_W = 6;
  localparam logic [CNT_W-1:0] CNT_ONE = 6'h01;

  typedef enum logic [2:0] {
    PNVBM_IDLE, PNVBM_SETUP, PNVBM_ACCESS, PNVBM_STROBE, PNVBM_WRHOLD, PNVBM_RELEASE, PNVBM_PRECHARGE
  } pnvbm_state_type;

  // User request
  typedef struct packed {
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } pnvbm_req_type;

  // Pins driven toward the memory
  typedef struct packed {
    logic select_low_active_n;
    logic select_high_active;
    logic write_strobe_n;
    logic output_gate_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq_out;
    logic dq_oe;
  } pnvbm_pins_type;
endpackage : pnvbm_pkg

// file: rtl/pnvbm_host.sv
module pnvbm_host (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic req_valid,
  input wire pnvbm_pkg::pnvbm_req_type req,
  input wire logic hold_open,
  output logic req_ready,
  output logic rsp_valid,
  output logic [pnvbm_pkg::DATA_W-1:0] rsp_data,
  output pnvbm_pkg::pnvbm_pins_type pins,
  input wire logic [pnvbm_pkg::DATA_W-1:0] dq_in
);
  import pnvbm_pkg::*;

  // Whole state of the controller in one record
  typedef struct packed {
    pnvbm_state_type st;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] cyc;
    logic open;
    logic pend;
    logic wr;
    logic req_ready;
    logic rsp_valid;
    logic [DATA_W-1:0] rsp_data;
    pnvbm_pins_type pins;
    logic [DATA_W-1:0] dq_s1;
    logic [DATA_W-1:0] dq_s2;
  } pnvbm_regs_type;

  // Present and next state
  pnvbm_regs_type s_reg;
  pnvbm_regs_type s_next;
  logic [ROW_W-1:0] req_row;
  logic [ROW_W-1:0] cur_row;
  logic same_row;
  logic take;
  logic close_now;

  // Power-on values: memory deselected, strobe and gate high, bus released
  localparam pnvbm_regs_type S_RESET = '{
    st: PNVBM_IDLE,
    cnt: '0,
    cyc: '0,
    open: 1'b0,
    pend: 1'b0,
    wr: 1'b0,
    req_ready: 1'b0,
    rsp_valid: 1'b0,
    rsp_data: '0,
    pins: '{
      select_low_active_n: 1'b1,
      select_high_active: 1'b0,
      write_strobe_n: 1'b1,
      output_gate_n: 1'b1,
      addr: '0,
      dq_out: '0,
      dq_oe: 1'b0
    },
    dq_s1: '0,
    dq_s2: '0
  };

  // Row part of the request and of the address on the pins
  assign req_row = req.addr[ADDR_W-1:COL_W];
  assign cur_row = s_reg.pins.addr[ADDR_W-1:COL_W];

  // Page access only when the wanted row is the one held open
  assign same_row = s_reg.open && (req_row == cur_row);

  // Request accepted only while ready is shown
  assign take = req_valid && s_reg.req_ready;

  // Idle row closed once its cycle time is over and no hold is asked
  assign close_now = s_reg.open && !hold_open && (s_reg.cyc == '0);

  // Sequencer for select, strobe, gate and data pins
  always_comb begin
    s_next = s_reg;
    // Two-stage capture of the data lines from the memory
    s_next.dq_s1 = dq_in;
    s_next.dq_s2 = s_reg.dq_s1;
    // Answer and ready pulses last one cycle unless a state renews them
    s_next.rsp_valid = 1'b0;
    s_next.req_ready = 1'b0;
    // Countdown timers stop at zero
    if (s_reg.cnt != '0) begin
      s_next.cnt = s_reg.cnt - CNT_ONE;
    end
    if (s_reg.cyc != '0) begin
      s_next.cyc = s_reg.cyc - CNT_ONE;
    end
    case (s_reg.st)
      PNVBM_IDLE: begin
        // Ready shown only while waiting here
        s_next.req_ready = 1'b1;
        if (take) begin
          s_next.req_ready = 1'b0;
          s_next.wr = req.write;
          s_next.pins.dq_out = req.wdata;
          if (same_row) begin
            // Page access in open row: only column bits change
            s_next.pins.addr = req.addr;
            s_next.cnt = CNT_W'(T_AAP_CYC);
            if (req.write) begin
              s_next.pins.output_gate_n = 1'b1; // Memory output off in the same cycle the host starts driving data
              s_next.pins.write_strobe_n = 1'b0; // One strobe per byte
              s_next.pins.dq_oe = 1'b1;
              s_next.st = PNVBM_STROBE;
            end else begin
              s_next.pins.output_gate_n = 1'b0;
              s_next.st = PNVBM_ACCESS;
            end
          end else if (s_reg.open) begin
            // Different row: deselect to precharge first
            s_next.pins.addr = req.addr; // Row address moves only while deselected
            s_next.pend = 1'b1;
            s_next.pins.select_low_active_n = 1'b1;
            s_next.pins.select_high_active = 1'b0;
            s_next.pins.output_gate_n = 1'b1;
            s_next.open = 1'b0;
            s_next.cnt = CNT_W'(T_PC_CYC);
            s_next.st = PNVBM_PRECHARGE;
          end else begin
            s_next.pins.addr = req.addr; // Address setup before select
            s_next.st = PNVBM_SETUP;
          end
        end else if (close_now) begin
          // Close row when no longer wanted; no request taken meanwhile
          s_next.req_ready = 1'b0;
          s_next.pins.select_low_active_n = 1'b1;
          s_next.pins.select_high_active = 1'b0;
          s_next.pins.output_gate_n = 1'b1;
          s_next.open = 1'b0;
          s_next.cnt = CNT_W'(T_PC_CYC);
          s_next.st = PNVBM_PRECHARGE;
        end
      end
      PNVBM_PRECHARGE: begin
        // Selects stay inactive for the whole precharge count
        if (s_reg.cnt <= CNT_ONE) begin
          if (s_reg.pend) begin
            // Row change: open the new row with the address already set
            s_next.st = PNVBM_SETUP;
          end else begin
            // Plain close: back to idle without any access
            s_next.st = PNVBM_IDLE;
          end
        end
      end
      PNVBM_SETUP: begin
        // Select edge latches the whole row; strobe held high for reads
        s_next.pins.select_low_active_n = 1'b0;
        s_next.pins.select_high_active = 1'b1;
        s_next.open = 1'b1;
        s_next.pend = 1'b0;
        s_next.cyc = CNT_W'(s_reg.wr ? T_WC_CYC : T_RC_CYC);
        s_next.cnt = CNT_W'(T_AA_CYC);
        if (s_reg.wr) begin
          s_next.pins.output_gate_n = 1'b1; // Memory output off before the host drives data
          s_next.pins.write_strobe_n = 1'b0; // Strobe-ended write; strobe falls in the same cycle as activation
          s_next.pins.dq_oe = 1'b1;
          s_next.st = PNVBM_STROBE;
        end else begin
          s_next.pins.output_gate_n = 1'b0;
          s_next.st = PNVBM_ACCESS;
        end
      end
      PNVBM_ACCESS: begin
        // Read data sampled after access time plus synchroniser delay
        if (s_reg.cnt == '0) begin
          s_next.cnt = CNT_W'(2);
          s_next.st = PNVBM_RELEASE;
        end
      end
      PNVBM_RELEASE: begin
        // Hand the settled byte to the user
        if (s_reg.cnt == '0) begin
          s_next.rsp_data = s_reg.dq_s2;
          s_next.rsp_valid = 1'b1;
          s_next.st = PNVBM_IDLE;
        end
      end
      PNVBM_STROBE: begin
        // Hold strobe until access time met, then rise to capture data
        if (s_reg.cnt == '0) begin
          s_next.pins.write_strobe_n = 1'b1;
          s_next.cnt = CNT_W'(T_HZ_CYC);
          s_next.st = PNVBM_WRHOLD;
        end
      end
      PNVBM_WRHOLD: begin
        // Data held past strobe rise; write done within the cycle
        if (s_reg.cnt == '0) begin
          s_next.pins.dq_oe = 1'b0;
          s_next.rsp_valid = 1'b1;
          s_next.st = PNVBM_IDLE;
        end
      end
      default: begin
        // Unused codes fall back to idle
        s_next.st = PNVBM_IDLE;
      end
    endcase
  end

  // State register; reset leaves memory deselected, strobe high
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      // Whole state back to its power-on value
      s_reg <= S_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from the state register
  assign req_ready = s_reg.req_ready;
  assign rsp_valid = s_reg.rsp_valid;
  assign rsp_data = s_reg.rsp_data;
  assign pins = s_reg.pins;
endmodule : pnvbm_host

// file: verification/pnvbm_mem_model.sv
module pnvbm_mem_model (
  input wire logic ref_clk,
  input wire pnvbm_pkg::pnvbm_pins_type pins,
  output logic [pnvbm_pkg::DATA_W-1:0] dq_level
);
  timeunit 1ns;
  timeprecision 1ps;
  import pnvbm_pkg::*;
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  pnvbm_pins_type prev_reg;
  logic [CNT_W-1:0] age_reg;
  logic [CNT_W-1:0] lim_reg;
  logic [DATA_W-1:0] last_reg = 8'h5A;
  logic sel;
  logic drive;
  // Selected only with both selects active
  assign sel = !pins.select_low_active_n && pins.select_high_active;
  assign drive = sel && !pins.output_gate_n && pins.write_strobe_n && age_reg >= lim_reg
    && pins.addr == prev_reg.addr;
  // Released bus shows a pattern that flips every cycle
  assign dq_level = pins.dq_oe ? pins.dq_out : (drive ? mem[pins.addr] : ~last_reg);
  // Access timer and write capture
  always_ff @(posedge ref_clk) begin
    prev_reg <= pins;
    last_reg <= dq_level;
    age_reg <= (age_reg == 6'h3F) ? age_reg : age_reg + 6'h01;
    if (sel && (prev_reg.select_low_active_n || !prev_reg.select_high_active
        || prev_reg.addr[16:3] != pins.addr[16:3])) begin
      age_reg <= 6'h01;
      lim_reg <= CNT_W'(T_AA_CYC);
    end else if (prev_reg.addr[2:0] != pins.addr[2:0]) begin
      age_reg <= 6'h01;
      lim_reg <= CNT_W'(T_AAP_CYC);
    end
    if (!prev_reg.write_strobe_n && (pins.write_strobe_n || !sel)) begin
      mem[prev_reg.addr] <= pins.dq_out;
    end
  end
endmodule : pnvbm_mem_model

// file: verification/pnvbm_host_asserts.sv
module pnvbm_host_asserts (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire pnvbm_pkg::pnvbm_pins_type pins
);
  timeunit 1ns;
  timeprecision 1ps;
  import pnvbm_pkg::*;
  logic [5:0] low_cnt_reg;
  logic [5:0] sel_cnt_reg;
  // Counts cycles with the strobe low, and cycles since both selects went active
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      low_cnt_reg <= 6'h00;
      sel_cnt_reg <= 6'h00;
    end else begin
      low_cnt_reg <= pins.write_strobe_n ? 6'h00 : low_cnt_reg + 6'h01;
      if (pins.select_low_active_n || !pins.select_high_active) begin
        sel_cnt_reg <= 6'h00;
      end else if (sel_cnt_reg != 6'h3F) begin
        sel_cnt_reg <= sel_cnt_reg + 6'h01;
      end
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence strobe_end;
    $rose(pins.write_strobe_n);
  endsequence
  a_strobe_gap: assert property (strobe_end |=> pins.write_strobe_n) else $error("strobe gap");
  a_write_long: assert property (strobe_end |-> low_cnt_reg >= T_AAP_CYC && sel_cnt_reg >= T_AA_CYC)
    else $error("write short");
  a_data_held: assert property (strobe_end |-> pins.dq_oe && $stable(pins.dq_out)) else $error("data");
  a_precharge_min: assert property ($rose(pins.select_low_active_n) |-> pins.select_low_active_n[*6])
    else $error("precharge");
  a_row_stable: assert property ($changed(pins.addr[16:3]) |-> pins.select_low_active_n) else $error("row");
  a_page_strobe: assert property ($fell(pins.write_strobe_n) |-> !pins.select_low_active_n
    && pins.select_high_active) else $error("strobe");
  a_reset_quiet: assert property (@(posedge ref_clk) disable iff (1'b0) rst |-> pins.write_strobe_n)
    else $error("reset strobe");
  a_one_access: assert property (req_valid && req_ready |=> !req_ready ##[1:40] rsp_valid)
    else $error("access");
endmodule : pnvbm_host_asserts
bind pnvbm_host pnvbm_host_asserts pnvbm_host_asserts_inst (.ref_clk, .rst, .req_valid, .req_ready, .rsp_valid, .pins);

// file: verification/testbench.sv
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin err_total++; \
  $display("[ERR] %s exp %h got %h", n, e, s); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import pnvbm_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b0;
  logic req_valid = 1'b0;
  logic hold_open = 1'b0;
  pnvbm_req_type req = '0;
  logic req_ready;
  logic rsp_valid;
  logic [DATA_W-1:0] rsp_data;
  logic [DATA_W-1:0] dq_level;
  logic [DATA_W-1:0] q;
  pnvbm_pins_type pins;
  int err_total = 0;
  int comparisons = 0;
  int cycles = 0;
  always #2.5 ref_clk = ~ref_clk;
  pnvbm_host pnvbm_host_inst (.ref_clk, .rst, .req_valid, .req, .hold_open, .req_ready, .rsp_valid,
    .rsp_data, .pins, .dq_in(dq_level));
  pnvbm_mem_model pnvbm_mem_model_inst (.ref_clk, .pins, .dq_level);
  task print_verdict;
    $display("checks %0d errors %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : print_verdict
  // Cuts a hang short
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      print_verdict();
    end
  end
  // One request, answer awaited under a bound
  task xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] r);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 60) begin @(posedge ref_clk); #1; n++; end
    req_valid = 1'b1;
    req = '{w, a, d};
    @(posedge ref_clk);
    #1 req_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 60) begin @(posedge ref_clk); #1; n++; end
    `CHK("rsp_valid", 1'b1, rsp_valid)
    r = rsp_data;
  endtask : xfer
  // Lowest and highest byte, each a fresh row
  task sc_edges;
    xfer(1'b1, 17'h00000, 8'hA5, q);
    xfer(1'b1, 17'h1FFFF, 8'h3C, q);
    xfer(1'b0, 17'h00000, 8'h00, q);
    `CHK("rd_lo", 8'hA5, q)
    xfer(1'b0, 17'h1FFFF, 8'h00, q);
    `CHK("rd_hi", 8'h3C, q)
  endtask : sc_edges
  // Whole row written and read back; every access after the first write is in page mode
  task sc_page;
    hold_open = 1'b1;
    for (int i = 0; i < 8; i++) xfer(1'b1, {14'h0155, 3'(i)}, 8'(8'h40 + i), q);
    for (int i = 7; i >= 0; i--) begin
      xfer(1'b0, {14'h0155, 3'(i)}, 8'h00, q);
      `CHK("page", 8'(8'h40 + i), q)
    end
    hold_open = 1'b0;
  endtask : sc_page
  // Row changes while the row is held open
  task sc_rows;
    hold_open = 1'b1;
    for (int i = 0; i < 4; i++) begin
      xfer(1'b0, i[0] ? 17'h1FFFF : 17'h00AAB, 8'h00, q);
      `CHK("row", i[0] ? 8'h3C : 8'h43, q)
    end
    hold_open = 1'b0;
  endtask : sc_rows
  initial begin
    #1 rst = 1'b1;
    repeat (3) @(posedge ref_clk);
    #1 rst = 1'b0;
    sc_edges();
    sc_page();
    sc_rows();
    print_verdict();
  end
endmodule : testbench
